// file: hw/bcd_div_pkg.sv
package bcd_div_pkg;

    // ------------------------------------------------------------
    // operation codes (ten-bit binary value of the function code)
    // ------------------------------------------------------------
    localparam logic [9:0] OP_DIV_WORD   = 10'h1B2; // single-word bcd divide, 434
    localparam logic [9:0] OP_DIV_DOUBLE = 10'h1B3; // double-word bcd divide, 435
    localparam logic [9:0] OP_BIN_WORD   = 10'h017; // single-word bcd to binary, 023
    localparam logic [9:0] OP_BIN_DOUBLE = 10'h03A; // double-word bcd to binary, 058
    localparam int         OP_CODE_W     = 10;      // least width of the code port

    // ------------------------------------------------------------
    // datapath geometry
    // ------------------------------------------------------------
    localparam int WORD_W     = 16;                 // one memory word
    localparam int DIGITS     = 8;                  // bcd digits of a double word
    localparam int CONV_STEPS = 8;                  // one digit per cycle
    localparam int DIV_STEPS  = 32;                 // one quotient bit per cycle
    localparam int DABB_STEPS = 32;                 // one shift per cycle

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [63:0] RESULT_RST = 64'h0;     // result words after reset
    localparam logic        FLAG_RST   = 1'b0;      // every flag after reset

    // ------------------------------------------------------------
    // sequencer states, gray coded along the divide path
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CONV = 3'h1,
        ST_DIV  = 3'h3,
        ST_DABB = 3'h2
    } seq_state_t;

endpackage

// file: hw/bcd_div_unit.sv
`timescale 1ns/1ps

// Operation
// - code 434 word divide, 435 double
// - code 023 word convert, 058 double
// - word divide: quotient word0, remainder word1
// - double divide: quotient words0-1, remainder 2-3
// - word divide fault: non-bcd operand or zero divisor
// - double divide fault: any non-bcd, zero divisor
// - word divide zero when quotient zero
// - double divide zero when quotient zero
// - word convert: four bcd digits to binary
// - double convert: eight digits to 32 bits
// - word convert fault on non-bcd digit
// - double convert fault on non-bcd word
// - word convert zero when result zero
// - double convert zero when result zero
module bcd_div_unit #(
    parameter int OPCODE_W = 10                        // width of the code port
) (
    input  wire logic                core_clk,         // system clock, 200 MHz
    input  wire logic                sys_rst,          // async reset, active high
    input  wire logic                clk_en,           // freezes all state when low
    input  wire logic                op_valid,         // sequencer issues an operation
    input  wire logic [OPCODE_W-1:0] op_code,          // function code of the operation
    input  wire logic [31:0]         dividend_operand, // dividend or source, word0 low
    input  wire logic [31:0]         divisor_operand,  // divisor, word0 low
    output logic                     busy,             // operation in progress
    output logic                     done,             // one cycle: flags valid, result too unless fault
    output logic                     result_we,        // one cycle: write result words
    output logic [63:0]              result_words,     // word0 in bits 15:0 upward
    output logic                     fault_flag,       // error flag
    output logic                     zero_flag,        // equals flag
    output logic                     sign_flag         // negative flag
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    // the decode reads op_code[9:0], so the port needs ten bits
    if (OPCODE_W < bcd_div_pkg::OP_CODE_W) begin : g_bad_width
        $error("op_code port too narrow for the operation codes");
    end

    // ------------------------------------------------------------
    // state record
    // ------------------------------------------------------------
    typedef struct packed {
        bcd_div_pkg::seq_state_t st;  // sequencer state
        logic [5:0]   cnt;            // step counter within a state
        logic         is_div;         // operation is a divide
        logic         is_dbl;         // operation is double word
        logic [31:0]  dd_bcd;         // dividend or source digits, shifting out
        logic [31:0]  dr_bcd;         // divisor digits, shifting out
        logic [31:0]  dd_bin;         // dividend or source in binary
        logic [31:0]  dr_bin;         // divisor in binary
        logic [31:0]  quo;            // quotient, later shifted out
        logic [31:0]  rem;            // partial remainder, later shifted out
        logic [31:0]  bq;             // quotient digits being built
        logic [31:0]  br;             // remainder digits being built
        logic         busy;           // output copy
        logic         done;           // output copy
        logic         we;             // output copy
        logic [63:0]  res;            // output copy
        logic         fault;          // output copy
        logic         zero;           // output copy
        logic         sign;           // output copy
    } unit_state_t;

    unit_state_t state_r;             // registered state
    unit_state_t state_nxt;           // next state

    // ------------------------------------------------------------
    // decode of the incoming request
    // ------------------------------------------------------------
    logic        req_take;            // request accepted this cycle
    logic        req_div;             // divide requested
    logic        req_dbl;             // double word requested
    logic        req_known;           // code is one of the four
    logic [31:0] dd_in;               // dividend or source, upper word masked on single-word ops
    logic [31:0] dr_in;               // divisor, upper word masked on single-word ops
    logic        dd_bad;              // dividend or source holds a non-bcd digit
    logic        dr_bad;              // divisor holds a non-bcd digit
    logic        dr_zero;             // divisor is zero
    logic        req_fault;           // request ends at once with a fault

    // true when any nibble of the value exceeds nine
    function automatic logic non_bcd(input logic [31:0] v);
        logic bad;
        bad = 1'b0;
        for (int i = 0; i < bcd_div_pkg::DIGITS; i++) begin
            if (v[4*i +: 4] > 4'h9) begin
                bad = 1'b1;
            end
        end
        return bad;
    endfunction

    // classify the code and mask the operands
    always_comb begin
        req_div   = 1'b0;
        req_dbl   = 1'b0;
        req_known = 1'b1;
        case (op_code[9:0])
            bcd_div_pkg::OP_DIV_WORD: begin
                req_div = 1'b1;
            end
            bcd_div_pkg::OP_DIV_DOUBLE: begin
                req_div = 1'b1;
                req_dbl = 1'b1;
            end
            bcd_div_pkg::OP_BIN_WORD: begin
                req_div = 1'b0;
            end
            bcd_div_pkg::OP_BIN_DOUBLE: begin
                req_dbl = 1'b1;
            end
            default: begin
                req_known = 1'b0;
            end
        endcase
        // single-word operations see only word0
        dd_in    = req_dbl ? dividend_operand : {16'h0000, dividend_operand[15:0]};
        dr_in    = req_dbl ? divisor_operand  : {16'h0000, divisor_operand[15:0]};
        dd_bad   = non_bcd(dd_in);
        dr_bad   = non_bcd(dr_in);
        dr_zero  = (dr_in == 32'h0000_0000);
        req_take = clk_en && op_valid && !state_r.busy && req_known;
        if (req_div) begin
            req_fault = dd_bad || dr_bad || dr_zero;
        end else begin
            req_fault = dd_bad;
        end
    end

    // ------------------------------------------------------------
    // per-digit add-three correction for the bcd builders
    // ------------------------------------------------------------
    logic [31:0] adj_q;               // corrected quotient digits
    logic [31:0] adj_r;               // corrected remainder digits

    for (genvar g = 0; g < bcd_div_pkg::DIGITS; g++) begin : g_adj
        // a digit of five or more gets three before the shift
        assign adj_q[4*g +: 4] = (state_r.bq[4*g +: 4] > 4'h4) ?
                                 state_r.bq[4*g +: 4] + 4'h3 : state_r.bq[4*g +: 4];
        assign adj_r[4*g +: 4] = (state_r.br[4*g +: 4] > 4'h4) ?
                                 state_r.br[4*g +: 4] + 4'h3 : state_r.br[4*g +: 4];
    end

    // ------------------------------------------------------------
    // datapath step terms
    // ------------------------------------------------------------
    logic [31:0] dd_acc;              // dividend times ten plus next digit
    logic [31:0] dr_acc;              // divisor times ten plus next digit
    logic [31:0] rem_sh;              // remainder with next dividend bit in
    logic        rem_ge;              // divisor fits the shifted remainder

    // accumulate one bcd digit and try one divide step
    always_comb begin
        dd_acc = (state_r.dd_bin << 3) + (state_r.dd_bin << 1)
               + {28'h0000000, state_r.dd_bcd[31:28]};
        dr_acc = (state_r.dr_bin << 3) + (state_r.dr_bin << 1)
               + {28'h0000000, state_r.dr_bcd[31:28]};
        rem_sh = {state_r.rem[30:0], state_r.quo[31]};
        rem_ge = (rem_sh >= state_r.dr_bin);
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt      = state_r;
        // strobes last one enabled cycle
        state_nxt.done = 1'b0;
        state_nxt.we   = 1'b0;
        case (state_r.st)
            bcd_div_pkg::ST_IDLE: begin
                if (req_take) begin
                    state_nxt.is_div = req_div;
                    state_nxt.is_dbl = req_dbl;
                    state_nxt.dd_bcd = dd_in;
                    state_nxt.dr_bcd = dr_in;
                    state_nxt.dd_bin = 32'h0000_0000;
                    state_nxt.dr_bin = 32'h0000_0000;
                    state_nxt.cnt    = 6'h00;
                    if (!req_div) begin
                        state_nxt.sign = 1'b0;
                    end
                    if (req_fault) begin
                        // bad operands: flags only, result words untouched
                        state_nxt.fault = 1'b1;
                        state_nxt.zero  = 1'b0;
                        state_nxt.done  = 1'b1;
                    end else begin
                        state_nxt.st   = bcd_div_pkg::ST_CONV;
                        state_nxt.busy = 1'b1;
                    end
                end
            end
            bcd_div_pkg::ST_CONV: begin
                // one decimal digit per cycle, most significant first
                state_nxt.dd_bin = dd_acc;
                state_nxt.dr_bin = dr_acc;
                state_nxt.dd_bcd = {state_r.dd_bcd[27:0], 4'h0};
                state_nxt.dr_bcd = {state_r.dr_bcd[27:0], 4'h0};
                state_nxt.cnt    = state_r.cnt + 6'h01;
                if (state_r.cnt == 6'(bcd_div_pkg::CONV_STEPS - 1)) begin
                    state_nxt.cnt = 6'h00;
                    if (state_r.is_div) begin
                        state_nxt.st  = bcd_div_pkg::ST_DIV;
                        state_nxt.quo = dd_acc;
                        state_nxt.rem = 32'h0000_0000;
                    end else begin
                        state_nxt.st    = bcd_div_pkg::ST_IDLE;
                        state_nxt.busy  = 1'b0;
                        state_nxt.done  = 1'b1;
                        state_nxt.we    = 1'b1;
                        state_nxt.fault = 1'b0;
                        if (state_r.is_dbl) begin
                            state_nxt.res  = {32'h0000_0000, dd_acc};
                            state_nxt.zero = (dd_acc == 32'h0000_0000);
                        end else begin
                            state_nxt.res  = {48'h0000_0000_0000, dd_acc[15:0]};
                            state_nxt.zero = (dd_acc[15:0] == 16'h0000);
                        end
                    end
                end
            end
            bcd_div_pkg::ST_DIV: begin
                // restoring division, one quotient bit per cycle
                state_nxt.rem = rem_ge ? rem_sh - state_r.dr_bin : rem_sh;
                state_nxt.quo = {state_r.quo[30:0], rem_ge};
                state_nxt.cnt = state_r.cnt + 6'h01;
                if (state_r.cnt == 6'(bcd_div_pkg::DIV_STEPS - 1)) begin
                    state_nxt.cnt = 6'h00;
                    state_nxt.st  = bcd_div_pkg::ST_DABB;
                    state_nxt.bq  = 32'h0000_0000;
                    state_nxt.br  = 32'h0000_0000;
                end
            end
            bcd_div_pkg::ST_DABB: begin
                // binary back to bcd by shift and add three
                state_nxt.bq  = {adj_q[30:0], state_r.quo[31]};
                state_nxt.br  = {adj_r[30:0], state_r.rem[31]};
                state_nxt.quo = {state_r.quo[30:0], 1'b0};
                state_nxt.rem = {state_r.rem[30:0], 1'b0};
                state_nxt.cnt = state_r.cnt + 6'h01;
                if (state_r.cnt == 6'(bcd_div_pkg::DABB_STEPS - 1)) begin
                    state_nxt.cnt   = 6'h00;
                    state_nxt.st    = bcd_div_pkg::ST_IDLE;
                    state_nxt.busy  = 1'b0;
                    state_nxt.done  = 1'b1;
                    state_nxt.we    = 1'b1;
                    state_nxt.fault = 1'b0;
                    if (state_r.is_dbl) begin
                        state_nxt.res  = {adj_r[30:0], state_r.rem[31],
                                          adj_q[30:0], state_r.quo[31]};
                        state_nxt.zero = ({adj_q[30:0], state_r.quo[31]} == 32'h0000_0000);
                    end else begin
                        state_nxt.res  = {32'h0000_0000, adj_r[14:0], state_r.rem[31],
                                          adj_q[14:0], state_r.quo[31]};
                        state_nxt.zero = ({adj_q[14:0], state_r.quo[31]} == 16'h0000);
                    end
                end
            end
            default: begin
                state_nxt.st   = bcd_div_pkg::ST_IDLE;
                state_nxt.busy = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r       <= '0;
            state_r.st    <= bcd_div_pkg::ST_IDLE;
            state_r.res   <= bcd_div_pkg::RESULT_RST;
            state_r.fault <= bcd_div_pkg::FLAG_RST;
            state_r.zero  <= bcd_div_pkg::FLAG_RST;
            state_r.sign  <= bcd_div_pkg::FLAG_RST;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from the state register
    // ------------------------------------------------------------
    assign busy         = state_r.busy;
    assign done         = state_r.done;
    assign result_we    = state_r.we;
    assign result_words = state_r.res;
    assign fault_flag   = state_r.fault;
    assign zero_flag    = state_r.zero;
    assign sign_flag    = state_r.sign;

endmodule

// file: sim/bcd_div_unit_chk.sv
`timescale 1ns/1ps
module bcd_div_unit_chk #(
    parameter int OPCODE_W = 10
) (
    input wire logic                core_clk,
    input wire logic                sys_rst,
    input wire logic                clk_en,
    input wire logic                op_valid,
    input wire logic [OPCODE_W-1:0] op_code,
    input wire logic [31:0]         dividend_operand,
    input wire logic [31:0]         divisor_operand,
    input wire logic                busy,
    input wire logic                done,
    input wire logic                result_we,
    input wire logic [63:0]         result_words,
    input wire logic                fault_flag,
    input wire logic                zero_flag,
    input wire logic                sign_flag
);
    // ----------------------------------------
    // helper: code of the operation in flight
    // ----------------------------------------
    logic [OPCODE_W-1:0] code_r;  // last taken code
    logic                take;    // request accepted this edge
    logic                conv;    // last taken was a conversion
    logic                dbl;     // last taken was a double op
    assign take = clk_en && op_valid && !busy && (op_code == bcd_div_pkg::OP_DIV_WORD
        || op_code == bcd_div_pkg::OP_DIV_DOUBLE || op_code == bcd_div_pkg::OP_BIN_WORD
        || op_code == bcd_div_pkg::OP_BIN_DOUBLE);
    assign conv = code_r == bcd_div_pkg::OP_BIN_WORD || code_r == bcd_div_pkg::OP_BIN_DOUBLE;
    assign dbl  = code_r == bcd_div_pkg::OP_DIV_DOUBLE || code_r == bcd_div_pkg::OP_BIN_DOUBLE;
    // remember the code at each take
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) code_r <= '0;
        else if (take) code_r <= op_code;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_bound;
        disable iff (sys_rst || !clk_en) take |-> ##[1:73] done;
    endproperty
    property p_conv_lat;
        take && (op_code == bcd_div_pkg::OP_BIN_WORD || op_code == bcd_div_pkg::OP_BIN_DOUBLE)
            ##1 (!done && clk_en) [*8] |=> done;
    endproperty
    property p_we_ok;
        result_we |-> done && !fault_flag;
    endproperty
    property p_fault_zero;
        done && fault_flag |-> !zero_flag;
    endproperty
    property p_zero_word;
        done && result_we && !dbl |-> zero_flag == (result_words[15:0] == 16'h0);
    endproperty
    property p_zero_dbl;
        done && result_we && dbl |-> zero_flag == (result_words[31:0] == 32'h0);
    endproperty
    property p_sign;
        done && conv |-> !sign_flag;
    endproperty
    property p_div_hi;
        done && result_we && code_r == bcd_div_pkg::OP_DIV_WORD |-> result_words[63:32] == 32'h0;
    endproperty
    property p_words;
        $changed(result_words) |-> $past(result_we, 1) || result_we;
    endproperty
    property p_flags;
        $changed(fault_flag) || $changed(zero_flag) |-> done;
    endproperty
    property p_freeze;
        !clk_en |=> $stable(busy) && $stable(result_words) && $stable(done);
    endproperty
    a_bound: assert property (p_bound) else $error("no done after take");
    a_conv_lat: assert property (p_conv_lat) else $error("conversion latency");
    a_we_ok: assert property (p_we_ok) else $error("write on fault");
    a_fault_zero: assert property (p_fault_zero) else $error("zero on fault");
    a_zero_word: assert property (p_zero_word) else $error("word zero flag");
    a_zero_dbl: assert property (p_zero_dbl) else $error("double zero flag");
    a_sign: assert property (p_sign) else $error("sign set on conversion");
    a_div_hi: assert property (p_div_hi) else $error("upper words not zero");
    a_words: assert property (p_words) else $error("words changed unwritten");
    a_flags: assert property (p_flags) else $error("flags changed off done");
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
    c_dbl_div: cover property (take && op_code == bcd_div_pkg::OP_DIV_DOUBLE);
    c_fault: cover property (done && fault_flag);
    c_conv_ok: cover property (result_we && conv);
endmodule

bind bcd_div_unit bcd_div_unit_chk #(.OPCODE_W(OPCODE_W)) u_bcd_div_unit_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .op_valid(op_valid),
    .op_code(op_code), .dividend_operand(dividend_operand), .divisor_operand(divisor_operand),
    .busy(busy), .done(done), .result_we(result_we), .result_words(result_words),
    .fault_flag(fault_flag), .zero_flag(zero_flag), .sign_flag(sign_flag));

// file: sim/word_mem_model.sv
`timescale 1ns/1ps
// result words land in memory only on a write strobe
module word_mem_model (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        result_we,
    input wire logic [63:0] result_words,
    output logic     [63:0] mem_r
);
    // capture the four result words on each write
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) mem_r <= 64'h0;
        else if (result_we) mem_r <= result_words;
    end
endmodule

// file: sim/bcd_div_unit_tb.sv
`timescale 1ns/1ps
module bcd_div_unit_tb;
    logic        core_clk = 1'b0;  // 200 MHz
    logic        sys_rst = 1'b1;   // held 5 cycles
    logic        clk_en = 1'b1;    // freeze control
    logic        op_valid = 1'b0;  // request
    logic [9:0]  op_code = 10'h000;
    logic [31:0] dividend_operand = 32'h0;
    logic [31:0] divisor_operand = 32'h0;
    logic        busy, done, result_we, fault_flag, zero_flag, sign_flag;
    logic [63:0] result_words;
    logic [63:0] mem;              // words stored by the memory model
    int          num_errors = 0;
    int          n_tests = 0;
    int          cyc = 0;
    bcd_div_unit u_bcd_div_unit (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .op_valid(op_valid), .op_code(op_code), .dividend_operand(dividend_operand),
        .divisor_operand(divisor_operand), .busy(busy), .done(done), .result_we(result_we),
        .result_words(result_words), .fault_flag(fault_flag), .zero_flag(zero_flag),
        .sign_flag(sign_flag));
    word_mem_model u_word_mem_model (.core_clk(core_clk), .sys_rst(sys_rst),
        .result_we(result_we), .result_words(result_words), .mem_r(mem));
    // clock, 5 ns period
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    // hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            give_verdict();
        end
    end
    // decimal value of eight bcd digits
    function automatic longint bval(logic [31:0] v);
        longint s;
        s = 0;
        for (int i = 7; i >= 0; i--) s = s * 10 + v[i*4 +: 4];
        return s;
    endfunction
    // eight bcd digits of a value
    function automatic logic [31:0] bcd(longint n);
        logic [31:0] r;
        for (int i = 0; i < 8; i++) begin
            r[i*4 +: 4] = 4'(n % 10);
            n = n / 10;
        end
        return r;
    endfunction
    // any digit above nine
    function automatic logic bad(logic [31:0] v);
        bad = 1'b0;
        for (int i = 0; i < 8; i++) bad = bad | (v[i*4 +: 4] > 4'h9);
    endfunction
    task automatic chk(string nm, logic [63:0] e, logic [63:0] s);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // issue one operation, optionally frozen fz cycles, and judge it
    task automatic do_op(logic [9:0] c, logic [31:0] a, logic [31:0] b, int fz);
        logic        dv, dbl, flt, inj;
        logic [31:0] ua, ub;
        longint      q, r;
        logic [63:0] ew, m0, mk;
        int          lat, n;
        dv = c == bcd_div_pkg::OP_DIV_WORD || c == bcd_div_pkg::OP_DIV_DOUBLE;
        dbl = c == bcd_div_pkg::OP_DIV_DOUBLE || c == bcd_div_pkg::OP_BIN_DOUBLE;
        ua = dbl ? a : {16'h0, a[15:0]};
        ub = dbl ? b : {16'h0, b[15:0]};
        flt = bad(ua) || (dv && (bad(ub) || ub == 32'h0));
        q = (dv && !flt) ? bval(ua) / bval(ub) : bval(ua);
        r = (dv && !flt) ? bval(ua) % bval(ub) : 0;
        ew = !dv ? {32'h0, 32'(q)} : dbl ? {bcd(r), bcd(q)} : {32'h0, 16'(bcd(r)), 16'(bcd(q))};
        mk = !dv ? (dbl ? 64'hFFFFFFFF : 64'hFFFF) : 64'hFFFFFFFFFFFFFFFF;
        lat = (flt ? 1 : dv ? 73 : 9) + fz;
        inj = dv && !flt && fz == 0;
        m0 = mem;
        @(posedge core_clk);
        op_valid <= 1'b1;
        op_code <= c;
        dividend_operand <= a;
        divisor_operand <= b;
        @(posedge core_clk);
        op_valid <= 1'b0;
        clk_en <= fz == 0;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
            if (n == fz) clk_en <= 1'b1;
            if (inj && n == 3) op_valid <= 1'b1;
            if (inj && n == 3) op_code <= bcd_div_pkg::OP_BIN_WORD;
            if (inj && n == 4) op_valid <= 1'b0;
        end while (done !== 1'b1 && n < 200);
        clk_en <= 1'b1;
        chk("latency", lat, n);
        chk("fault_flag", flt, fault_flag);
        chk("result_we", !flt, result_we);
        chk("zero_flag", !flt && q == 0, zero_flag);
        if (!dv) chk("sign_flag", 0, sign_flag);
        @(posedge core_clk);
        chk("done pulse", 0, done);
        chk("words", (flt ? m0 : ew) & mk, mem & mk);
    endtask
    task automatic t_reset();
        chk("reset state", 0, {busy, done, result_we, fault_flag, zero_flag, sign_flag});
        chk("reset words", 64'h0, result_words);
        $display("t_reset done");
    endtask
    task automatic t_div();
        do_op(bcd_div_pkg::OP_DIV_WORD, 32'hFFFF0100, 32'h00000003, 0);
        do_op(bcd_div_pkg::OP_DIV_WORD, 32'h00000002, 32'h00000005, 0);
        do_op(bcd_div_pkg::OP_DIV_WORD, 32'h00009999, 32'h00000001, 0);
        do_op(bcd_div_pkg::OP_DIV_DOUBLE, 32'h12345678, 32'h00000123, 0);
        do_op(bcd_div_pkg::OP_DIV_DOUBLE, 32'h99999999, 32'h00010000, 20);
        do_op(bcd_div_pkg::OP_DIV_DOUBLE, 32'h00000005, 32'h00010000, 0);
        $display("t_div done");
    endtask
    task automatic t_fault();
        do_op(bcd_div_pkg::OP_DIV_WORD, 32'h000000A0, 32'h00000001, 0);
        do_op(bcd_div_pkg::OP_DIV_WORD, 32'h00000100, 32'h12340000, 0);
        do_op(bcd_div_pkg::OP_DIV_DOUBLE, 32'h00000001, 32'h00000000, 0);
        do_op(bcd_div_pkg::OP_DIV_DOUBLE, 32'h00000001, 32'h00B00001, 0);
        do_op(bcd_div_pkg::OP_BIN_WORD, 32'h000012F4, 32'h0, 0);
        do_op(bcd_div_pkg::OP_BIN_DOUBLE, 32'hA0000001, 32'h0, 0);
        $display("t_fault done");
    endtask
    task automatic t_conv();
        do_op(bcd_div_pkg::OP_BIN_WORD, 32'h00001234, 32'h0, 0);
        do_op(bcd_div_pkg::OP_BIN_WORD, 32'h55550000, 32'h0, 0);
        do_op(bcd_div_pkg::OP_BIN_WORD, 32'h00009999, 32'h0, 0);
        do_op(bcd_div_pkg::OP_BIN_DOUBLE, 32'h99999999, 32'h0, 0);
        do_op(bcd_div_pkg::OP_BIN_DOUBLE, 32'h00010000, 32'h0, 10);
        do_op(bcd_div_pkg::OP_BIN_DOUBLE, 32'h00000000, 32'h0, 0);
        $display("t_conv done");
    endtask
    task automatic t_unknown();
        @(posedge core_clk);
        op_valid <= 1'b1;
        op_code <= 10'h3FF;
        @(posedge core_clk);
        op_valid <= 1'b0;
        // look at every edge so that a one-cycle done pulse cannot slip by
        repeat (3) begin
            @(posedge core_clk);
            chk("unknown code ignored", 0, {busy, done, result_we});
        end
        $display("t_unknown done");
    endtask
    task automatic give_verdict();
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_div();
        t_fault();
        t_conv();
        t_unknown();
        give_verdict();
    end
endmodule
